/* rtl/rimc_top.sv */
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "rimc_defs.svh"
module rimc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // First group event pulses / levels
  input wire rimc_pkg::rimc_byte_t ev_group1_i,
  // Second group events
  input wire logic sync_det_i,
  input wire logic rx_packet_done_i,
  input wire logic preamble_det_i,
  input wire logic sync_timeout_i,
  input wire logic preamble_invalid_i,
  input wire logic rssi_above_i,
  input wire logic wake_timer_expired_i,
  input wire logic low_battery_i,
  input wire logic por_event_i,
  input wire logic packet_sent_i,
  input wire logic packet_valid_i,
  // Analogue and mode controls
  output logic irq_out_n,
  output logic lbd_enable_o,
  output logic wake_timer_run_o,
  output logic low_freq_osc_select,
  output logic tx_on_o,
  output logic rx_on_o,
  output logic synth_on_o,
  output logic xtal_on_o
);
  import rimc_pkg::*;

  rimc_settle_if sif ();

  rimc_byte_t ien1;
  rimc_byte_t ien2;
  rimc_byte_t mode1;
  rimc_byte_t cfg;
  rimc_byte_t stat1;
  rimc_byte_t stat2;
  rimc_byte_t raw2;
  rimc_byte_t next_stat1;
  rimc_byte_t next_stat2;
  logic ready_q;

  ////////////////////////////////////////////////////////////////
  // Bus decode
  function automatic logic byte_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    byte_hit = (adr == reg_adr);
  endfunction : byte_hit

  // Read clears only the enabled flags
  function automatic rimc_byte_t rd_clear(input rimc_byte_t flags, input rimc_byte_t en,
                                          input logic rd);
    rd_clear = rd ? (flags & ~en) : flags;
  endfunction : rd_clear

  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_lane = bus_req && wb_we_i && wb_sel_i[0];
  wire wr_ien1 = wr_lane && byte_hit(wb_adr_i, `RIMC_ADR_IEN1);
  wire wr_ien2 = wr_lane && byte_hit(wb_adr_i, `RIMC_ADR_IEN2);
  wire wr_mode = wr_lane && byte_hit(wb_adr_i, `RIMC_ADR_MODE1);
  wire wr_cfg = wr_lane && byte_hit(wb_adr_i, `RIMC_ADR_CFG);
  wire rd_stat1 = bus_req && !wb_we_i && byte_hit(wb_adr_i, `RIMC_ADR_STATUS1);
  wire rd_stat2 = bus_req && !wb_we_i && byte_hit(wb_adr_i, `RIMC_ADR_STATUS2);
  wire sw_reset = wr_mode && wb_dat_i[`RIMC_M_SWRES];
  wire soft_rst = rst_i || sw_reset;

  ////////////////////////////////////////////////////////////////
  // Second group raw levels
  wire chip_ready = sif.chip_ready;
  wire preval_set = preamble_det_i;
  wire preval_clr = sync_det_i || sync_timeout_i;
  always_comb begin
    raw2 = 8'h00;
    raw2[`RIMC_B_RSSI] = rssi_above_i;
    raw2[`RIMC_B_CHIPRDY] = chip_ready;
  end

  ////////////////////////////////////////////////////////////////
  // Gated set events
  wire wut_set = wake_timer_expired_i && mode1[`RIMC_M_WTEN];
  wire lbd_set = low_battery_i && mode1[`RIMC_M_LBDEN];
  wire preval_only = preval_set && !preval_clr;

  // Chip ready edge, level follow and self-clear controls
  wire rdy_rise = raw2[`RIMC_B_CHIPRDY] && !ready_q;
  wire rdy_level = raw2[`RIMC_B_CHIPRDY] && !ien2[`RIMC_B_CHIPRDY];
  wire rdy_drop = !ien2[`RIMC_B_CHIPRDY];
  wire preinv_drop = !ien2[`RIMC_B_PREINV];

  ////////////////////////////////////////////////////////////////
  // First group next value: sticky events, set wins over read clear
  always_comb begin
    next_stat1 = rd_clear(stat1, ien1, rd_stat1);
    next_stat1 = next_stat1 | ev_group1_i;
  end

  // Second group next value, set wins over read clear
  always_comb begin
    next_stat2 = rd_clear(stat2, ien2, rd_stat2);
    // Event-driven bits
    if (rx_packet_done_i) next_stat2[`RIMC_B_SYNC] = 1'b0;
    if (sync_det_i) next_stat2[`RIMC_B_SYNC] = 1'b1;
    if (preval_clr) next_stat2[`RIMC_B_PREVAL] = 1'b0;
    if (preval_only) next_stat2[`RIMC_B_PREVAL] = 1'b1;
    // Invalid preamble drops next cycle unless held for the interrupt
    if (preinv_drop) next_stat2[`RIMC_B_PREINV] = 1'b0;
    if (preamble_invalid_i) next_stat2[`RIMC_B_PREINV] = 1'b1;
    next_stat2[`RIMC_B_RSSI] = (ien2[`RIMC_B_RSSI] && next_stat2[`RIMC_B_RSSI]) ||
                               raw2[`RIMC_B_RSSI];
    if (wut_set) next_stat2[`RIMC_B_WUT] = 1'b1;
    if (lbd_set) next_stat2[`RIMC_B_LBD] = 1'b1;
    if (rdy_drop) next_stat2[`RIMC_B_CHIPRDY] = 1'b0;
    if (rdy_rise) next_stat2[`RIMC_B_CHIPRDY] = 1'b1;
    if (rdy_level) next_stat2[`RIMC_B_CHIPRDY] = 1'b1;
    if (por_event_i) next_stat2[`RIMC_B_POR] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // First group flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat1 <= `RIMC_RST_STAT1;
    end else begin
      stat1 <= next_stat1;
    end
  end

  // Second group flags, power-on flag set out of reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat2 <= `RIMC_RST_STAT2;
    end else begin
      stat2 <= next_stat2;
    end
  end

  // Chip ready history for the rising-edge set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= chip_ready;
    end
  end

  ////////////////////////////////////////////////////////////////
  // First group enables
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      ien1 <= `RIMC_RST_IEN1;
    end else if (wr_ien1) begin
      ien1 <= wb_dat_i[7:0];
    end
  end

  // Second group enables
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      ien2 <= `RIMC_RST_IEN2;
    end else if (wr_ien2) begin
      ien2 <= wb_dat_i[7:0];
    end
  end

  // Packet mode configuration
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      cfg <= `RIMC_RST_CFG;
    end else if (wr_cfg) begin
      cfg <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode control register with auto clears
  wire fifo_mode = cfg[`RIMC_C_FIFO];
  wire tx_done = fifo_mode && packet_sent_i;
  wire rx_done = packet_valid_i && !cfg[`RIMC_C_MULTI];
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      mode1 <= `RIMC_RST_MODE1;
    end else begin
      if (wr_mode) mode1 <= {1'b0, wb_dat_i[6:0]};
      if (tx_done) mode1[`RIMC_M_TXON] <= 1'b0;
      if (rx_done) mode1[`RIMC_M_RXON] <= 1'b0;
    end
  end

  // Oscillator request to settle timer
  assign sif.osc_req = mode1[`RIMC_M_XTON] || mode1[`RIMC_M_TXON] ||
                       mode1[`RIMC_M_RXON] || mode1[`RIMC_M_PLLON];

  rimc_settle u_settle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////
  // Interrupt pending from next flag values
  wire irq_pend1 = |(next_stat1 & ien1);
  wire irq_pend2 = |(next_stat2 & ien2);
  wire irq_pend = irq_pend1 || irq_pend2;

  // Active-low interrupt line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !irq_pend;
    end
  end

  // Battery detector enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lbd_enable_o <= 1'b0;
    end else begin
      lbd_enable_o <= mode1[`RIMC_M_LBDEN];
    end
  end

  // Wake timer run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_timer_run_o <= 1'b0;
    end else begin
      wake_timer_run_o <= mode1[`RIMC_M_WTEN];
    end
  end

  // Low-frequency oscillator choice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_freq_osc_select <= 1'b0;
    end else begin
      low_freq_osc_select <= mode1[`RIMC_M_LFSEL];
    end
  end

  // Transmit request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_on_o <= 1'b0;
    end else begin
      tx_on_o <= mode1[`RIMC_M_TXON];
    end
  end

  // Receive request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_on_o <= 1'b0;
    end else begin
      rx_on_o <= mode1[`RIMC_M_RXON];
    end
  end

  // Synthesizer on for tune, transmit or receive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      synth_on_o <= 1'b0;
    end else begin
      synth_on_o <= mode1[`RIMC_M_PLLON] || mode1[`RIMC_M_TXON] ||
                    mode1[`RIMC_M_RXON];
    end
  end

  // Crystal on for crystal, tune, transmit or receive request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_on_o <= 1'b0;
    end else begin
      xtal_on_o <= sif.osc_req;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read mux and acknowledge
  logic [7:0] rd_byte;
  always_comb begin
    case (wb_adr_i)
      `RIMC_ADR_STATUS1: rd_byte = stat1;
      `RIMC_ADR_STATUS2: rd_byte = stat2;
      `RIMC_ADR_IEN1: rd_byte = ien1;
      `RIMC_ADR_IEN2: rd_byte = ien2;
      `RIMC_ADR_MODE1: rd_byte = mode1;
      `RIMC_ADR_CFG: rd_byte = cfg;
      default: rd_byte = 8'h00;
    endcase
  end

  // Acknowledge one cycle after the take
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Registered read data, zero outside the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= bus_req ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end
endmodule : rimc_top

/* rtl/rimc_defs.svh */
`ifndef RIMC_DEFS_SVH
`define RIMC_DEFS_SVH

// Register byte addresses (index times four)
`define RIMC_IDX_STATUS1 8'h03
`define RIMC_IDX_STATUS2 8'h04
`define RIMC_IDX_IEN1 8'h05
`define RIMC_IDX_IEN2 8'h06
`define RIMC_IDX_MODE1 8'h07
`define RIMC_ADR_STATUS1 8'h0c
`define RIMC_ADR_STATUS2 8'h10
`define RIMC_ADR_IEN1 8'h14
`define RIMC_ADR_IEN2 8'h18
`define RIMC_ADR_MODE1 8'h1c
`define RIMC_ADR_CFG 8'h40

// Reset values
`define RIMC_RST_IEN1 8'h00
`define RIMC_RST_IEN2 8'h03
`define RIMC_RST_MODE1 8'h00
`define RIMC_RST_CFG 8'h00
`define RIMC_RST_STAT1 8'h00
`define RIMC_RST_STAT2 8'h01

// Second status group bit positions
`define RIMC_B_SYNC 7
`define RIMC_B_PREVAL 6
`define RIMC_B_PREINV 5
`define RIMC_B_RSSI 4
`define RIMC_B_WUT 3
`define RIMC_B_LBD 2
`define RIMC_B_CHIPRDY 1
`define RIMC_B_POR 0

// Mode control bit positions
`define RIMC_M_SWRES 7
`define RIMC_M_LBDEN 6
`define RIMC_M_WTEN 5
`define RIMC_M_LFSEL 4
`define RIMC_M_TXON 3
`define RIMC_M_RXON 2
`define RIMC_M_PLLON 1
`define RIMC_M_XTON 0

// Config register bits
`define RIMC_C_FIFO 0
`define RIMC_C_MULTI 1

// Crystal settling time in ns and cycles at 10 ns
`define RIMC_XTAL_SETTLE_NS 1000
`define RIMC_CLK_NS 10
`define RIMC_XTAL_SETTLE_CYC ((`RIMC_XTAL_SETTLE_NS + `RIMC_CLK_NS - 1) / `RIMC_CLK_NS)

`endif

/* rtl/rimc_pkg.sv */
package rimc_pkg;
  typedef logic [7:0] rimc_byte_t;
  typedef enum logic [2:0] {
    RIMC_IDLE = 3'b001,
    RIMC_SETTLE = 3'b010,
    RIMC_READY = 3'b100
  } rimc_xtal_state_t;
endpackage : rimc_pkg

/* rtl/rimc_settle_if.sv */
`timescale 1ns/1ps
interface rimc_settle_if;
  logic osc_req;
  logic chip_ready;
  modport ctrl (output osc_req, input chip_ready);
  modport timer (input osc_req, output chip_ready);
endinterface : rimc_settle_if

/* rtl/rimc_settle.sv */
`timescale 1ns/1ps
`include "rimc_defs.svh"
module rimc_settle (
  input wire logic clk_i,
  input wire logic rst_i,
  rimc_settle_if.timer sif
);
  import rimc_pkg::*;

  localparam int CNT_MAX = `RIMC_XTAL_SETTLE_CYC;
  rimc_xtal_state_t state;
  rimc_xtal_state_t next_state;
  logic [15:0] cnt;
  wire cnt_done = (cnt == 16'(CNT_MAX - 1));

  ////////////////////////////////////////////////////////////////
  // Crystal settle sequence
  always_comb begin
    next_state = state;
    case (state)
      RIMC_IDLE: begin
        if (sif.osc_req) next_state = RIMC_SETTLE;
      end
      RIMC_SETTLE: begin
        if (!sif.osc_req) next_state = RIMC_IDLE;
        else if (cnt_done) next_state = RIMC_READY;
      end
      RIMC_READY: begin
        if (!sif.osc_req) next_state = RIMC_IDLE;
      end
      default: next_state = RIMC_IDLE;
    endcase
  end

  // State and counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RIMC_IDLE;
      cnt <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= (state == RIMC_SETTLE) ? cnt + 16'h0001 : 16'h0000;
    end
  end

  // Ready holds until idle
  assign sif.chip_ready = (state == RIMC_READY);
endmodule : rimc_settle

/* verification/rimc_top_sva.sv */
`timescale 1ns/1ps
module rimc_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sync_det_i,
  input wire rimc_pkg::rimc_byte_t ev_group1_i,
  input wire logic irq_out_n,
  input wire logic lbd_enable_o,
  input wire logic tx_on_o,
  input wire logic synth_on_o,
  input wire logic xtal_on_o
);
  import rimc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // Taken requests and shadow copies of both enable registers
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = take & wb_we_i & wb_sel_i[0];
  wire swr = wr & (wb_adr_i == 8'h1c) & wb_dat_i[7];
  rimc_byte_t ien1;
  rimc_byte_t ien2;
  // Shadow follows writes, reset and soft reset
  always_ff @(posedge clk_i) begin
    if (rst_i || swr) begin
      ien1 <= 8'h00;
      ien2 <= 8'h03;
    end else if (wr && wb_adr_i == 8'h14) begin
      ien1 <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == 8'h18) begin
      ien2 <= wb_dat_i[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_take;
    take;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_take |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_dat;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat: assert property (p_dat) else $error("read data without ack");
  property p_ien1;
    s_take ##0 (!wb_we_i && wb_adr_i == 8'h14) |=> wb_dat_o == {24'h0, ien1};
  endproperty
  a_ien1: assert property (p_ien1) else $error("enable one readback");
  property p_ien2;
    s_take ##0 (!wb_we_i && wb_adr_i == 8'h18) |=> wb_dat_o == {24'h0, ien2};
  endproperty
  a_ien2: assert property (p_ien2) else $error("enable two readback");
  property p_irq;
    (sync_det_i && ien2[7]) || (|(ev_group1_i & ien1)) |-> ##[1:2] !irq_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled event gave no irq");
  property p_swres;
    swr |-> ##2 (!lbd_enable_o && !tx_on_o && !xtal_on_o);
  endproperty
  a_swres: assert property (p_swres) else $error("soft reset left controls");
  property p_lbd;
    wr && wb_adr_i == 8'h1c && !wb_dat_i[7] |-> ##2 lbd_enable_o == $past(wb_dat_i[6], 2);
  endproperty
  a_lbd: assert property (p_lbd) else $error("battery detector enable");
  property p_pwr;
    (tx_on_o || synth_on_o) |-> (synth_on_o && xtal_on_o);
  endproperty
  a_pwr: assert property (p_pwr) else $error("synth or crystal off");
endmodule : rimc_top_sva

/* verification/rimc_radio_model.sv */
`timescale 1ns/1ps
module rimc_radio_model (
  input wire logic clk_i,
  input wire logic [3:0] code_i,
  output logic [9:0] pulse_o
);
  // One single-cycle event per code 1 to 10, quiet on zero and on codes above 10
  always_ff @(posedge clk_i) begin
    pulse_o <= (code_i == 4'h0) ? 10'h000 : 10'h001 << (code_i - 4'h1);
  end
endmodule : rimc_radio_model

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import rimc_pkg::*;
  logic clk_i, rst_i, cyc, we, ack, rssi, irq_n, lbd, wut, lf, tx, rx, syn, xt;
  logic [7:0] adr;
  logic [31:0] dat, dat_o, q;
  rimc_byte_t g1;
  logic [3:0] code;
  logic [9:0] pulse;
  int error_cnt, checks_done;
  rimc_top u_rimc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ev_group1_i(g1), .sync_det_i(pulse[0]), .rx_packet_done_i(pulse[1]),
    .preamble_det_i(pulse[2]), .sync_timeout_i(pulse[3]), .preamble_invalid_i(pulse[4]),
    .rssi_above_i(rssi), .wake_timer_expired_i(pulse[5]), .low_battery_i(pulse[6]),
    .por_event_i(pulse[7]), .packet_sent_i(pulse[8]), .packet_valid_i(pulse[9]),
    .irq_out_n(irq_n), .lbd_enable_o(lbd), .wake_timer_run_o(wut), .low_freq_osc_select(lf),
    .tx_on_o(tx), .rx_on_o(rx), .synth_on_o(syn), .xtal_on_o(xt));
  rimc_radio_model u_rimc_radio_model (.clk_i(clk_i), .code_i(code), .pulse_o(pulse));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ckb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : ckb
  // One classic cycle, held until ack is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    if (ack !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    cyc <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask : rc
  // Far-side event code and first group pulse
  task automatic ev(input logic [3:0] c, input rimc_byte_t g);
    @(posedge clk_i);
    code <= c;
    g1 <= g;
    @(posedge clk_i);
    code <= 4'h0;
    g1 <= 8'h00;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : ev
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_i, cyc, we, adr, dat, g1, code, rssi} = {1'b1, 55'h0};
    error_cnt = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(8'h18, 8'h03);
    rc(8'h1c, 8'h00);
    rc(8'h44, 8'h00);
    ckb(irq_n, 1'b0);
    rc(8'h10, 8'h01);
    ckb(irq_n, 1'b1);
    rc(8'h10, 8'h00);
    wr(8'h18, 8'h00);
    for (int b = 0; b < 8; b++) begin
      rimc_byte_t m;
      m = 8'h01 << b;
      wr(8'h14, m);
      rc(8'h14, m);
      ev(4'h0, m);
      ckb(irq_n, 1'b0);
      rc(8'h0c, m);
      ckb(irq_n, 1'b1);
    end
    ev(4'h3, 8'h00);
    rc(8'h10, 8'h40);
    ev(4'h1, 8'h00);
    rc(8'h10, 8'h80);
    ev(4'h2, 8'h00);
    rc(8'h10, 8'h00);
    ev(4'h3, 8'h00);
    ev(4'h4, 8'h00);
    ev(4'h5, 8'h00);
    rc(8'h10, 8'h00);
    wr(8'h18, 8'h21);
    ev(4'h5, 8'h00);
    ev(4'h8, 8'h00);
    ckb(irq_n, 1'b0);
    rc(8'h10, 8'h21);
    ckb(irq_n, 1'b1);
    @(posedge clk_i);
    rssi <= 1'b1;
    rc(8'h10, 8'h10);
    @(posedge clk_i);
    rssi <= 1'b0;
    rc(8'h10, 8'h00);
    wr(8'h18, 8'h80);
    ev(4'h1, 8'h00);
    ckb(irq_n, 1'b0);
    rc(8'h10, 8'h80);
    ckb(irq_n, 1'b1);
    wr(8'h1c, 8'h40);
    ckb(lbd, 1'b1);
    ev(4'h7, 8'h00);
    ckb(irq_n, 1'b1);
    wr(8'h18, 8'h04);
    ckb(irq_n, 1'b0);
    rc(8'h10, 8'h04);
    wr(8'h18, 8'h08);
    wr(8'h1c, 8'h20);
    ckb(wut, 1'b1);
    ev(4'h6, 8'h00);
    ckb(irq_n, 1'b0);
    rc(8'h10, 8'h08);
    wr(8'h1c, 8'h10);
    ckb(lf, 1'b1);
    wr(8'h1c, 8'h01);
    ckb(xt, 1'b1);
    rc(8'h10, 8'h00);
    repeat (100) @(posedge clk_i);
    rc(8'h10, 8'h02);
    wr(8'h1c, 8'h02);
    ckb(syn, 1'b1);
    rc(8'h10, 8'h02);
    wr(8'h1c, 8'h00);
    rc(8'h10, 8'h00);
    wr(8'h40, 8'h01);
    wr(8'h1c, 8'h08);
    ckb(tx, 1'b1);
    ev(4'h9, 8'h00);
    rc(8'h1c, 8'h00);
    wr(8'h1c, 8'h04);
    ckb(rx, 1'b1);
    ev(4'ha, 8'h00);
    rc(8'h1c, 8'h00);
    wr(8'h40, 8'h03);
    wr(8'h1c, 8'h04);
    ev(4'ha, 8'h00);
    rc(8'h1c, 8'h04);
    wr(8'h1c, 8'h08);
    wr(8'h1c, 8'h00);
    ckb(tx, 1'b0);
    wr(8'h18, 8'h80);
    wr(8'h14, 8'h01);
    ev(4'h1, 8'h01);
    rc(8'h10, 8'h80);
    ckb(irq_n, 1'b0);
    bus(1'b0, 8'h0c, 8'h00);
    ckb(irq_n, 1'b1);
    wr(8'h14, 8'hff);
    wr(8'h1c, 8'hc1);
    rc(8'h1c, 8'h00);
    rc(8'h18, 8'h03);
    rc(8'h14, 8'h00);
    finish_test();
  end
endmodule : testbench
bind rimc_top rimc_top_sva u_rimc_top_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_det_i(sync_det_i),
  .ev_group1_i(ev_group1_i), .irq_out_n(irq_out_n), .lbd_enable_o(lbd_enable_o),
  .tx_on_o(tx_on_o), .synth_on_o(synth_on_o), .xtal_on_o(xtal_on_o));
